// >>> rtl/fdsc_defines.vh
// Constants for the fluorescent display scan controller
`ifndef FDSC_DEFINES_VH
`define FDSC_DEFINES_VH
// Register byte offsets on the AXI4-Lite bus
`define FDSC_OFS_DCR 16'h0000
`define FDSC_OFS_SCR 16'h0004
`define FDSC_OFS_DSR 16'h0008
`define FDSC_OFS_IRQ 16'h000c
`define FDSC_OFS_STAT 16'h0010
// Display RAM window, one word per digit
`define FDSC_RAM_BASE 16'hfec0
`define FDSC_RAM_LAST 16'hfeff
// Reset values
`define FDSC_DCR_RST 8'h00
`define FDSC_SCR_RST 8'h00
`define FDSC_DSR_RST 8'h20
`define FDSC_DSR_ONES 8'h20
// Digit control register fields
`define FDSC_DCR_TSEL 7
`define FDSC_DCR_WAVE_HI 6
`define FDSC_DCR_WAVE_LO 4
`define FDSC_DCR_DR_HI 3
// Segment control register fields
`define FDSC_SCR_VALID 7
`define FDSC_SCR_KSE 6
`define FDSC_SCR_SR_HI 4
// Digit start register fields
`define FDSC_DSR_EN 7
`define FDSC_DSR_DISPLAY_ON 6
`define FDSC_DSR_FPS_TOP 3
// Interrupt register fields
`define FDSC_IRQ_FLAG 0
`define FDSC_IRQ_EN 1
// Slot lengths in cycles minus one, per digit time select
`define FDSC_SLOT_SHORT 12'd1023
`define FDSC_SLOT_LONG 12'd2047
// Pin counts and limits
`define FDSC_SEG_LAST 5'd23
`define FDSC_DIG_LAST 4'd15
`define FDSC_SHARED 5'd8
`define FDSC_DIG_SHARED 4'd8
// AXI responses
`define FDSC_RESP_OKAY 2'b00
`define FDSC_RESP_SLVERR 2'b10
`endif

// >>> rtl/fdsc_ram.v
// Display RAM: 16 words, byte-strobed write port and two read ports
`timescale 1ns/100ps
module fdsc_ram (
  input wire ref_clk,
  input wire wr_en,
  input wire [3:0] wr_idx,
  input wire [31:0] wr_data,
  input wire [3:0] wr_strb,
  input wire [3:0] rd_a_idx,
  output wire [31:0] rd_a_data,
  input wire [3:0] rd_b_idx,
  output wire [31:0] rd_b_data
);
  // Storage, one word holds the four bytes of a digit
  reg [31:0] mem [0:15];

  // Scan port and bus port read combinationally
  assign rd_a_data = mem[rd_a_idx];
  assign rd_b_data = mem[rd_b_idx];

  // Each byte lane writes on its own strobe
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      always @(posedge ref_clk) begin
        if (wr_en && wr_strb[g]) begin
          mem[wr_idx][8*g+7:8*g] <= wr_data[8*g+7:8*g];
        end
      end
    end
  endgenerate
endmodule // fdsc_ram

// >>> rtl/fdsc_timer.v
// Display timing generator: digit slots and the key-scan slot
`timescale 1ns/100ps
`include "fdsc_defines.vh"
module fdsc_timer (
  input wire ref_clk,
  input wire reset_n,
  input wire hold,
  input wire long_slot,
  input wire key_scan_en,
  input wire [3:0] first_digit,
  input wire [3:0] last_digit,
  output reg [3:0] digit_ff,
  output reg [11:0] slot_cnt_ff,
  output reg in_scan_ff,
  output reg scan_start_ff
);
  // Last count of the current slot length
  wire [11:0] slot_last = long_slot ? `FDSC_SLOT_LONG : `FDSC_SLOT_SHORT;
  wire slot_end = (slot_cnt_ff == slot_last);
  wire frame_end = (digit_ff == last_digit) || (digit_ff > last_digit);

  // Step through digits, then the optional key-scan slot
  always @(posedge ref_clk) begin
    scan_start_ff <= 1'b0;
    if (!reset_n || hold) begin
      digit_ff <= first_digit;
      slot_cnt_ff <= 12'h000;
      in_scan_ff <= 1'b0;
    end else if (!slot_end) begin
      slot_cnt_ff <= slot_cnt_ff + 12'h001;
    end else begin
      slot_cnt_ff <= 12'h000;
      if (in_scan_ff) begin
        // Key-scan slot over, new frame
        in_scan_ff <= 1'b0;
        digit_ff <= first_digit;
      end else if (frame_end) begin
        // One extra digit-length slot when key scan is on
        in_scan_ff <= key_scan_en;
        scan_start_ff <= key_scan_en;
        digit_ff <= first_digit;
      end else begin
        // Next enabled digit in turn
        digit_ff <= digit_ff + 4'h1;
      end
    end
  end
endmodule // fdsc_timer

// >>> rtl/fdsc_top.v
// Fluorescent display scan controller with AXI4-Lite registers
// Summary of operation
// - 24 segments, 16 digits, 8 shared pins
// - Frame timing from digit slots per frame
// - Key scan adds one slot, pins free
// - Key-scan slot: all pins low, pulled down
// - Segment data from RAM FEC0 to FEFF
// - Four RAM bytes per digit, stride four
// - Unused RAM is plain read/write RAM
// - Pin valid flag gives pins to display
// - Key-scan enable adds the key-scan slot
// - Range fields select operational segments, digits
// - Value 0011 starts digit 3, segment 5
// - Display on drives segments, enable starts scan
// - Key-scan slot start sets interrupt flag
// - Interrupt reaches CPU only when enabled
// - Control register write restarts scan timing
// - Display off: segments low, digits scan
// - Enable clear holds scan in reset
// - First-pin select splits the shared pins
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "fdsc_defines.vh"
module fdsc_top (
  input wire ref_clk,
  input wire reset_n,
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [15:0] digit_pin,
  output wire [15:0] digit_pin_en,
  output wire [23:0] segment_pin,
  output wire [23:0] segment_pin_en,
  output wire pin_pull_down,
  output wire key_scan_active,
  output wire key_scan_irq
);
  // Write channel state
  reg aw_hold_ff; // Write address taken
  reg w_hold_ff; // Write data taken
  reg [15:0] awaddr_ff; // Captured write address
  reg [31:0] wdata_ff; // Captured write data
  reg [3:0] wstrb_ff; // Captured write strobes
  reg bvalid_ff; // Write response pending
  reg [1:0] bresp_ff; // Write response code
  // Read channel state
  reg rvalid_ff; // Read data pending
  reg [31:0] rdata_ff; // Read data
  reg [1:0] rresp_ff; // Read response code
  // Control registers
  reg [7:0] digit_control_register_ff; // Time select, waveform, digit range
  reg [7:0] segment_control_register_ff; // Pin valid, key scan, segment range
  reg [7:0] digit_start_register_ff; // Enable, display on, first pin
  reg key_scan_irq_flag_ff; // Sticky key-scan request
  reg key_scan_irq_enable_ff; // Request mask
  reg irq_out_ff; // Request to the CPU
  // Pin drivers
  reg [15:0] digit_pin_ff; // Digit drive levels
  reg [15:0] digit_pin_en_ff; // Digit pins in display use
  reg [23:0] segment_pin_ff; // Segment drive levels
  reg [23:0] segment_pin_en_ff; // Segment pins in display use
  reg pull_down_ff; // Pins held pulled down
  reg scan_slot_ff; // Key-scan slot, pin aligned
  reg restart_ff; // Control register write seen last cycle
  // Next values of the pin drivers
  reg [15:0] nxt_digit_pin;
  reg [15:0] nxt_digit_pin_en;
  reg [23:0] nxt_segment_pin;
  reg [23:0] nxt_segment_pin_en;

  // Field views of the control registers
  wire digit_time_select = digit_control_register_ff[`FDSC_DCR_TSEL];
  wire [2:0] digit_waveform_field = digit_control_register_ff[`FDSC_DCR_WAVE_HI:`FDSC_DCR_WAVE_LO];
  wire [3:0] digit_range_field = digit_control_register_ff[`FDSC_DCR_DR_HI:0];
  wire pin_valid_flag = segment_control_register_ff[`FDSC_SCR_VALID];
  wire key_scan_enable = segment_control_register_ff[`FDSC_SCR_KSE];
  wire [4:0] segment_range_field = segment_control_register_ff[`FDSC_SCR_SR_HI:0];
  wire controller_enable = digit_start_register_ff[`FDSC_DSR_EN];
  wire display_on = digit_start_register_ff[`FDSC_DSR_DISPLAY_ON];
  wire [3:0] first_pin_select = digit_start_register_ff[`FDSC_DSR_FPS_TOP:0];

  // Timer outputs
  wire [3:0] cur_digit;
  wire [11:0] slot_cnt;
  wire in_scan;
  wire scan_start;
  // RAM read data
  wire [31:0] scan_word;
  wire [31:0] bus_word;

  // Bus handshakes; holds block new beats until the response goes
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready = !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Write happens once both address and data are held
  wire do_write = aw_hold_ff && w_hold_ff;
  wire lane0 = wstrb_ff[0];
  wire wr_dcr = do_write && (awaddr_ff == `FDSC_OFS_DCR);
  wire wr_scr = do_write && (awaddr_ff == `FDSC_OFS_SCR);
  wire wr_dsr = do_write && (awaddr_ff == `FDSC_OFS_DSR);
  wire wr_irq = do_write && (awaddr_ff == `FDSC_OFS_IRQ);
  wire wr_stat = do_write && (awaddr_ff == `FDSC_OFS_STAT);
  // Display RAM window decode on address bits 15 to 6
  wire wr_ram = do_write && (awaddr_ff[15:6] == `FDSC_RAM_BASE >> 6);
  wire rd_ram = (s_axi_araddr[15:6] == `FDSC_RAM_BASE >> 6);
  wire wr_hit = wr_dcr || wr_scr || wr_dsr || wr_irq || wr_stat || wr_ram;
  // A low-lane write to the digit control, segment control or digit start register restarts the scan
  wire reinit = (wr_dcr || wr_scr || wr_dsr) && lane0;

  // Write address and data capture, in either order
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 16'h0000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `FDSC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[15:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        // Both held: answer one cycle later
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `FDSC_RESP_OKAY : `FDSC_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Control register writes; low byte lane only
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      digit_control_register_ff <= `FDSC_DCR_RST;
      segment_control_register_ff <= `FDSC_SCR_RST;
      digit_start_register_ff <= `FDSC_DSR_RST;
      key_scan_irq_enable_ff <= 1'b0;
    end else begin
      if (wr_dcr && lane0) begin
        digit_control_register_ff <= wdata_ff[7:0];
      end
      if (wr_scr && lane0) begin
        segment_control_register_ff <= wdata_ff[7:0];
      end
      if (wr_dsr && lane0) begin
        // Bit 5 stays one
        digit_start_register_ff <= wdata_ff[7:0] | `FDSC_DSR_ONES;
      end
      if (wr_irq && lane0) begin
        key_scan_irq_enable_ff <= wdata_ff[`FDSC_IRQ_EN];
      end
    end
  end

  // Sticky key-scan flag; a set in the clearing cycle wins
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      key_scan_irq_flag_ff <= 1'b0;
      irq_out_ff <= 1'b0;
    end else begin
      if (scan_start) begin
        key_scan_irq_flag_ff <= 1'b1;
      end else if (wr_irq && lane0 && wdata_ff[`FDSC_IRQ_FLAG]) begin
        // Write one to clear
        key_scan_irq_flag_ff <= 1'b0;
      end
      // Masked unless enabled
      irq_out_ff <= key_scan_irq_flag_ff && key_scan_irq_enable_ff;
    end
  end
  assign key_scan_irq = irq_out_ff;

  // Read data mux
  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[15:2], 2'b00})
      `FDSC_OFS_DCR: rd_mux[7:0] = digit_control_register_ff;
      `FDSC_OFS_SCR: rd_mux[7:0] = segment_control_register_ff;
      `FDSC_OFS_DSR: rd_mux[7:0] = digit_start_register_ff;
      `FDSC_OFS_IRQ: begin
        rd_mux[`FDSC_IRQ_FLAG] = key_scan_irq_flag_ff;
        rd_mux[`FDSC_IRQ_EN] = key_scan_irq_enable_ff;
      end
      // Live scan state: slot count, key-scan slot, digit
      `FDSC_OFS_STAT: rd_mux = {11'h000, slot_cnt, in_scan, 4'h0, cur_digit};
      default: begin
        // Whole RAM readable, used by display or not
        rd_mux = bus_word;
        rd_hit = rd_ram;
      end
    endcase
  end

  // Read channel; answer the cycle after the address is taken
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `FDSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_hit ? rd_mux : 32'h0000_0000;
      rresp_ff <= rd_hit ? `FDSC_RESP_OKAY : `FDSC_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Display RAM; digit d owns the word at base plus 4*d
  fdsc_ram u_ram (
    .ref_clk(ref_clk),
    .wr_en(wr_ram),
    .wr_idx(awaddr_ff[5:2]),
    .wr_data(wdata_ff),
    .wr_strb(wstrb_ff),
    .rd_a_idx(cur_digit),
    .rd_a_data(scan_word),
    .rd_b_idx(s_axi_araddr[5:2]),
    .rd_b_data(bus_word)
  );

  // Shared pin split from first-pin select
  wire [3:0] first_digit = first_pin_select[3] ? `FDSC_DIG_SHARED : {1'b0, first_pin_select[2:0]};
  wire [4:0] first_seg = first_pin_select[3] ? 5'd0 : (`FDSC_SHARED - {2'b00, first_pin_select[2:0]});
  // Operational ranges from the range fields
  wire [3:0] last_digit = `FDSC_DIG_LAST - digit_range_field;
  wire [4:0] last_seg = (segment_range_field > `FDSC_SEG_LAST) ? `FDSC_SEG_LAST : segment_range_field;

  // Second hold cycle, so the timer reloads the newly written first digit
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= reinit;
    end
  end

  // Timer held in reset while disabled or on a reinit
  fdsc_timer u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .hold(!controller_enable || reinit || restart_ff),
    .long_slot(digit_time_select),
    .key_scan_en(key_scan_enable),
    .first_digit(first_digit),
    .last_digit(last_digit),
    .digit_ff(cur_digit),
    .slot_cnt_ff(slot_cnt),
    .in_scan_ff(in_scan),
    .scan_start_ff(scan_start)
  );

  // Waveform field blanks the tail of each slot in eighths
  wire [11:0] slot_last = digit_time_select ? `FDSC_SLOT_LONG : `FDSC_SLOT_SHORT;
  wire [11:0] blank = digit_time_select ? {1'b0, digit_waveform_field, 8'h00} : {2'b00, digit_waveform_field, 7'h00};
  wire [12:0] lit_sum = {1'b0, slot_cnt} + {1'b0, blank};
  wire lit = (lit_sum <= {1'b0, slot_last});
  // Scanning and not in the key-scan slot
  wire run = controller_enable && pin_valid_flag && !in_scan;

  // Per digit pin: selected and lit in its own slot
  genvar gd;
  generate
    for (gd = 0; gd < 16; gd = gd + 1) begin : dig
      localparam integer DN = gd;
      localparam [3:0] DI = DN[3:0];
      wire ok = (DI >= first_digit) && (DI <= last_digit);
      always @* begin
        // Display use follows pin valid, digit range and key-scan slot, not enable
        nxt_digit_pin_en[gd] = pin_valid_flag && ok && !in_scan;
        nxt_digit_pin[gd] = run && ok && (cur_digit == DI) && lit;
      end
    end
  endgenerate

  // Per segment pin: RAM bit of the current digit's word
  genvar gs;
  generate
    for (gs = 0; gs < 24; gs = gs + 1) begin : seg
      localparam integer SN = gs;
      localparam [4:0] SI = SN[4:0];
      wire ok = (SI >= first_seg) && (SI <= last_seg);
      always @* begin
        nxt_segment_pin_en[gs] = pin_valid_flag && ok && !in_scan;
        // Display off keeps segments dark, digits still scan
        nxt_segment_pin[gs] = run && display_on && ok && scan_word[gs] && lit;
      end
    end
  endgenerate

  // Pin registers; key-scan slot drives all pin levels and enables low
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      digit_pin_ff <= 16'h0000;
      digit_pin_en_ff <= 16'h0000;
      segment_pin_ff <= 24'h000000;
      segment_pin_en_ff <= 24'h000000;
      pull_down_ff <= 1'b0;
      scan_slot_ff <= 1'b0;
    end else begin
      digit_pin_ff <= nxt_digit_pin;
      digit_pin_en_ff <= nxt_digit_pin_en;
      segment_pin_ff <= nxt_segment_pin;
      segment_pin_en_ff <= nxt_segment_pin_en;
      pull_down_ff <= pin_valid_flag && (in_scan || !display_on);
      scan_slot_ff <= in_scan;
    end
  end

  // Pin outputs
  assign digit_pin = digit_pin_ff;
  assign digit_pin_en = digit_pin_en_ff;
  assign segment_pin = segment_pin_ff;
  assign segment_pin_en = segment_pin_en_ff;
  assign pin_pull_down = pull_down_ff;
  assign key_scan_active = scan_slot_ff;
endmodule // fdsc_top

// >>> dv/fdsc_panel.sv
// Display panel model: records the segment pattern shown on each digit
`timescale 1ns/100ps
module fdsc_panel (
  input wire ref_clk,
  input wire [15:0] digit_pin,
  input wire [23:0] segment_pin
);
  logic [23:0] seen [16]; // Last pattern lit on each digit
  int bad = 0; // Cycles with more than one digit lit
  // Start with a dark grid
  initial begin
    foreach (seen[d]) seen[d] = 24'h000000;
  end
  // Sample the grid at mid-cycle, once the pins have settled
  always @(negedge ref_clk) begin
    if (!$onehot0(digit_pin)) bad++;
    for (int d = 0; d < 16; d++) begin
      if (digit_pin === 16'h0001 << d) seen[d] <= segment_pin;
    end
  end
endmodule // fdsc_panel

// >>> dv/fdsc_chk_assertions.sv
// Port checker for the display scan controller
`timescale 1ns/100ps
module fdsc_chk (
  input wire ref_clk,
  input wire reset_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] digit_pin,
  input wire [15:0] digit_pin_en,
  input wire [23:0] segment_pin,
  input wire [23:0] segment_pin_en,
  input wire pin_pull_down,
  input wire key_scan_active,
  input wire key_scan_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] seg_rev; // Shared segment enables in digit order
  // Mirror shared segment enables onto digit numbering
  always_comb begin
    for (int k = 0; k < 8; k++) seg_rev[k] = segment_pin_en[7-k];
  end
  shared_pin_excl_a: assert property ((digit_pin_en[7:0] & seg_rev) == 8'h00)
    else $error("shared pin enabled both ways");
  one_digit_a: assert property ($onehot0(digit_pin))
    else $error("more than one digit lit");
  drive_needs_en_a: assert property (((digit_pin & ~digit_pin_en) | (segment_pin & ~segment_pin_en)) == 0)
    else $error("pin driven without display use");
  scan_dark_a: assert property (key_scan_active |-> digit_pin == 16'h0000 && segment_pin == 24'h000000)
    else $error("pin lit in key-scan slot");
  scan_free_a: assert property (key_scan_active |-> digit_pin_en == 16'h0000)
    else $error("digit pin kept in key-scan slot");
  scan_length_a: assert property ($rose(key_scan_active) |-> key_scan_active [*8])
    else $error("key-scan slot too short");
  pull_dark_a: assert property (pin_pull_down |-> segment_pin == 24'h000000)
    else $error("segment lit while pulled down");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  cover property ($rose(key_scan_active));
  cover property ($rose(key_scan_irq));
  cover property ($rose(pin_pull_down));
endmodule // fdsc_chk
bind fdsc_top fdsc_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .digit_pin(digit_pin), .digit_pin_en(digit_pin_en), .segment_pin(segment_pin),
  .segment_pin_en(segment_pin_en), .pin_pull_down(pin_pull_down), .key_scan_active(key_scan_active),
  .key_scan_irq(key_scan_irq));

// >>> dv/tb.sv
// Self-checking bench for the display scan controller
`timescale 1ns/100ps
module tb;
  logic ref_clk = 0, reset_n = 0;
  logic [15:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, ks_act, ks_irq, pull;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] dig, dig_en;
  wire [23:0] seg, seg_en;
  int fail_count = 0, n_compared = 0, n;
  logic [31:0] rd_d;
  logic [1:0] rd_r, wr_r;
  logic seen_any;
  // Free-running system clock
  initial forever #10 ref_clk = ~ref_clk;
  fdsc_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .digit_pin(dig),
    .digit_pin_en(dig_en), .segment_pin(seg), .segment_pin_en(seg_en), .pin_pull_down(pull),
    .key_scan_active(ks_act), .key_scan_irq(ks_irq));
  fdsc_panel u_panel (.ref_clk(ref_clk), .digit_pin(dig), .segment_pin(seg));
  // Display RAM test pattern per digit
  function logic [31:0] pat(input int d);
    return 32'hc3a55a00 + d * 32'h01020411;
  endfunction
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A wait that ran out counts as a mismatch and ends the run
  task hang(input string nm);
    chk(nm, 0, 1);
    give_verdict;
  endtask
  // Bus write: address and data offered together, each dropped once taken
  task wr(input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid === 1'b1) break;
    end
    wr_r = bresp;
    bready <= 0;
    if (i == 60) hang("write response");
  endtask
  // Bus read: data and response land in rd_d and rd_r
  task rd(input logic [15:0] a);
    int i;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid === 1'b1) break;
    end
    rd_d = rdata;
    rd_r = rresp;
    rready <= 0;
    if (i == 60) hang("read data");
  endtask
  // Bounded wait for a digit pattern, or for a key-scan slot level
  task wt(input bit by_digit, input logic [15:0] v);
    for (n = 0; n < 20000; n++) begin
      @(negedge ref_clk);
      if (by_digit ? dig === v : ks_act === v[0]) break;
    end
    if (n == 20000) hang("pin wait");
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1;
    for (int i = 0; i < 4; i++) begin
      rd(16'(4 * i));
      chk("reset value", rd_d, i == 2 ? 32'h20 : 32'h0);
    end
    rd(16'h0100);
    chk("unmapped resp", rd_r, 2'b10);
    chk("unmapped data", rd_d, 32'h0);
    wr(16'h0100, 32'h5);
    chk("unmapped wresp", wr_r, 2'b10);
    chk("pins idle", dig_en, 16'h0000);
    // Fill and read back display RAM, top byte included
    for (int d = 0; d < 16; d++) wr(16'hfec0 + 16'(4 * d), pat(d));
    for (int d = 0; d < 16; d++) begin
      rd(16'hfec0 + 16'(4 * d));
      chk("ram word", rd_d, pat(d));
    end
    // Start-up: digits 3 to 15, segments 5 to 23, key scan on, enables last
    wr(16'h0000, 32'h00);
    chk("write resp", wr_r, 2'b00);
    wr(16'h0004, 32'hdb);
    wr(16'h000c, 32'h02);
    wr(16'h0008, 32'hc3);
    @(negedge ref_clk);
    chk("digit enables", dig_en, 16'hfff8);
    chk("segment enables", seg_en, 24'hffffe0);
    wt(0, 16'h1);
    for (int d = 3; d < 16; d++) chk("lit pattern", u_panel.seen[d], pat(d) & 32'hffffe0);
    chk("unused digit", u_panel.seen[2], 32'h0);
    chk("overlap", u_panel.bad, 32'h0);
    chk("slot digits", {dig, dig_en}, 32'h0);
    chk("slot segments", seg, 32'h0);
    chk("slot pull", pull, 1'b1);
    repeat (3) @(negedge ref_clk);
    chk("irq raised", ks_irq, 1'b1);
    rd(16'h000c);
    chk("flag set", rd_d, 32'h3);
    wr(16'h000c, 32'h03);
    @(negedge ref_clk);
    chk("irq cleared", ks_irq, 1'b0);
    // Masked: flag still set at the next slot, request held back
    wr(16'h000c, 32'h00);
    wt(0, 16'h0);
    wt(0, 16'h1);
    repeat (3) @(negedge ref_clk);
    chk("irq masked", ks_irq, 1'b0);
    rd(16'h000c);
    chk("flag masked", rd_d, 32'h1);
    // Key scan off: a whole frame passes with no key-scan slot
    wr(16'h0004, 32'h9b);
    seen_any = 0;
    repeat (15000) begin
      @(negedge ref_clk);
      seen_any |= ks_act;
    end
    chk("no key slot", seen_any, 1'b0);
    wr(16'h0004, 32'hdb);
    // Control write in mid-frame restarts at the first digit
    wt(1, 16'h0100);
    wr(16'h0000, 32'h00);
    wt(1, 16'h0008);
    chk("restart", n < 8, 1'b1);
    // Display off: segments dark and pulled, digits still scan
    wr(16'h0008, 32'h83);
    wt(1, 16'h0010);
    chk("dark segments", seg, 32'h0);
    chk("pulled down", pull, 1'b1);
    rd(16'h0008);
    chk("start reg kept", rd_d, 32'ha3);
    // Controller disabled: no digit lit, pin use unchanged
    wr(16'h0008, 32'h43);
    seen_any = 0;
    repeat (2100) begin
      @(negedge ref_clk);
      seen_any |= |dig;
    end
    chk("held", seen_any, 1'b0);
    chk("enables kept", dig_en, 16'hfff8);
    wr(16'h0004, 32'h5b);
    @(negedge ref_clk);
    chk("released", |{dig_en, seg_en}, 1'b0);
    wr(16'h0004, 32'hdb);
    // First-pin select values 0 to 8, top bit included
    for (int i = 0; i <= 8; i++) begin
      wr(16'h0008, 32'hc0 | i);
      @(negedge ref_clk);
      chk("fps digits", dig_en, i < 8 ? 16'(16'hffff << i) : 16'hff00);
      chk("fps segments", seg_en, i < 8 ? 24'(24'hffffff << (8 - i)) : 24'hffffff);
    end
    // Narrowed ranges: digits 8 to 11, segments 0 to 15
    wr(16'h0000, 32'h04);
    @(negedge ref_clk);
    chk("digit range", dig_en, 16'h0f00);
    wr(16'h0004, 32'hcf);
    @(negedge ref_clk);
    chk("segment range", seg_en, 24'h00ffff);
    // Dimmer: waveform 7 leaves only the first eighth of each slot lit
    wr(16'h0000, 32'h74);
    @(negedge ref_clk);
    chk("dim start", dig, 16'h0100);
    repeat (300) @(negedge ref_clk);
    chk("dim tail", dig, 16'h0000);
    give_verdict;
  end
endmodule // tb
